// [core/roac_core.sv]
// rtc oscillator control, load capacitance stepping and alarm configuration
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module roac_core (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire roac_pkg::roac_bus_t i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_osc_amplitude_ok,
  input wire logic i_rtc_tick,
  input wire logic [31:0] i_timer_value,
  input wire logic [2:0][31:0] i_alarm_value,
  output logic o_gain_control_enable,
  output logic o_oscillator_mode_select,
  output logic o_bias_double_enable,
  output logic o_low_freq_osc_select,
  output logic o_crystal_select,
  output logic [3:0] o_cap_code,
  output logic o_timer_clear,
  output logic o_irq
);

  // true when a write strobe hits the given offset
  function automatic logic wr_hit(input roac_pkg::roac_bus_t b,
                                  input logic [7:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction

  // exact 32-bit compare gated by the alarm enable
  function automatic logic alarm_hit(input logic en,
                                     input logic [31:0] t,
                                     input logic [31:0] m);
    alarm_hit = en && (t == m);
  endfunction

  localparam logic [7:0] STEP_LAST =
    8'(roac_pkg::CAP_STEP_CYCLES - 1);

  // ---------------- amplitude detector synchroniser ----------------
  logic amp_meta_ff;
  logic amp_sync_ff;

  // analog comparator output is asynchronous to i_mclk
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      amp_meta_ff <= 1'b0;
      amp_sync_ff <= 1'b0;
    end else begin
      amp_meta_ff <= i_osc_amplitude_ok;
      amp_sync_ff <= amp_meta_ff;
    end
  end

  // ---------------- configuration registers ----------------
  roac_pkg::roac_osc_t osc_ff;
  roac_pkg::roac_osc_t nxt_osc;
  logic cap_step_en_ff;
  logic nxt_cap_step_en;
  logic [3:0] cap_target_ff;
  logic [3:0] nxt_cap_target;

  // software writes; reserved bits are simply not stored
  always_comb begin
    nxt_osc = osc_ff;
    nxt_cap_step_en = cap_step_en_ff;
    nxt_cap_target = cap_target_ff;
    if (wr_hit(i_bus, roac_pkg::ADDR_OSC_CTRL)) begin
      nxt_osc.gain = i_bus.wdata[roac_pkg::OSC_GAIN_BIT];
      nxt_osc.mode = i_bus.wdata[roac_pkg::OSC_MODE_BIT];
      nxt_osc.bias = i_bus.wdata[roac_pkg::OSC_BIAS_BIT];
      nxt_osc.lfo = i_bus.wdata[roac_pkg::OSC_LFO_BIT];
    end
    if (wr_hit(i_bus, roac_pkg::ADDR_CAP_CFG)) begin
      nxt_cap_step_en = i_bus.wdata[roac_pkg::CAP_STEP_BIT];
      nxt_cap_target = i_bus.wdata[roac_pkg::CAP_CODE_LSB +: 4];
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      osc_ff <= roac_pkg::OSC_RESET;
      cap_step_en_ff <= 1'b0;
      cap_target_ff <= roac_pkg::CAP_CODE_RESET;
    end else begin
      osc_ff <= nxt_osc;
      cap_step_en_ff <= nxt_cap_step_en;
      cap_target_ff <= nxt_cap_target;
    end
  end

  // oscillator controls straight from the register flops
  assign o_gain_control_enable = osc_ff.gain;
  assign o_oscillator_mode_select = osc_ff.mode;
  assign o_bias_double_enable = osc_ff.bias;
  assign o_low_freq_osc_select = osc_ff.lfo;
  // internal oscillator wins over the crystal/self-oscillate choice
  assign o_crystal_select = osc_ff.mode && !osc_ff.lfo;

  logic osc_valid;
  // no doubled bias means the detector reading is not trusted
  assign osc_valid = amp_sync_ff && osc_ff.bias;

  // ---------------- capacitance stepper ----------------
  logic [7:0] step_cnt_ff;
  logic [7:0] nxt_step_cnt;
  logic [3:0] cap_applied_ff;
  logic [3:0] nxt_cap_applied;
  logic step_pulse;
  logic cap_ready;

  assign step_pulse = (step_cnt_ff == STEP_LAST);
  assign cap_ready = (cap_applied_ff == cap_target_ff);

  // slow steps keep the oscillator from losing lock on a big change
  always_comb begin
    nxt_step_cnt = step_pulse ? 8'h00 : step_cnt_ff + 8'h01;
    nxt_cap_applied = cap_applied_ff;
    if (!cap_step_en_ff) begin
      nxt_cap_applied = cap_target_ff;
    end else if (step_pulse && !cap_ready) begin
      if (cap_applied_ff < cap_target_ff) begin
        nxt_cap_applied = cap_applied_ff + 4'h1;
      end else begin
        nxt_cap_applied = cap_applied_ff - 4'h1;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      step_cnt_ff <= 8'h00;
      cap_applied_ff <= roac_pkg::CAP_CODE_RESET;
    end else begin
      step_cnt_ff <= nxt_step_cnt;
      cap_applied_ff <= nxt_cap_applied;
    end
  end

  assign o_cap_code = cap_applied_ff;

  // ---------------- alarms and auto clear ----------------
  roac_pkg::roac_alarm_t alarm_ff;
  roac_pkg::roac_alarm_t nxt_alarm;
  logic [2:0] match_prev_ff;
  logic [2:0] match_now;
  logic [2:0] alarm_event;
  logic clear_pending_ff;
  logic nxt_clear_pending;
  logic timer_clear_ff;
  logic nxt_timer_clear;
  logic alm_wr;

  assign alm_wr = wr_hit(i_bus, roac_pkg::ADDR_ALARM_CFG);

  // a match level lasts many cycles, so only its rising edge counts
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      match_now[i] = alarm_hit(alarm_ff.enable[i], i_timer_value,
                               i_alarm_value[i]);
    end
    alarm_event = match_now & ~match_prev_ff;
  end

  // flags: written zero clears, written one keeps; new event wins
  always_comb begin
    nxt_alarm = alarm_ff;
    nxt_clear_pending = clear_pending_ff;
    nxt_timer_clear = 1'b0;
    if (alm_wr) begin
      nxt_alarm.flag = alarm_ff.flag &
        i_bus.wdata[roac_pkg::ALM_FLAG_LSB +: 3];
      nxt_alarm.auto_clear = i_bus.wdata[roac_pkg::ALM_AUTO_BIT];
      nxt_alarm.enable = i_bus.wdata[roac_pkg::ALM_EN_LSB +: 3];
    end
    nxt_alarm.flag = nxt_alarm.flag | alarm_event;
    // only alarm zero leaving its match arms the clear
    if (alarm_ff.auto_clear && match_prev_ff[0] && !match_now[0]) begin
      nxt_clear_pending = 1'b1;
    end
    // fire on the first oscillator tick after the deassert
    if (clear_pending_ff && i_rtc_tick) begin
      nxt_timer_clear = 1'b1;
      nxt_clear_pending = 1'b0;
    end
    if (!alarm_ff.auto_clear) begin
      nxt_clear_pending = 1'b0;
      nxt_timer_clear = 1'b0;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      alarm_ff <= roac_pkg::ALARM_RESET;
      match_prev_ff <= 3'h0;
      clear_pending_ff <= 1'b0;
      timer_clear_ff <= 1'b0;
    end else begin
      alarm_ff <= nxt_alarm;
      match_prev_ff <= match_now;
      clear_pending_ff <= nxt_clear_pending;
      timer_clear_ff <= nxt_timer_clear;
    end
  end

  assign o_timer_clear = timer_clear_ff;

  // ---------------- interrupt status, clear, enable ----------------
  logic [3:0] irq_status_ff;
  logic [3:0] nxt_irq_status;
  logic [3:0] irq_enable_ff;
  logic [3:0] nxt_irq_enable;
  logic cap_ready_prev_ff;
  logic [3:0] irq_event;

  assign irq_event = {cap_ready && !cap_ready_prev_ff, alarm_event};

  // clear register is write-one-to-clear; a same-cycle event survives
  always_comb begin
    nxt_irq_status = irq_status_ff;
    nxt_irq_enable = irq_enable_ff;
    if (wr_hit(i_bus, roac_pkg::ADDR_IRQ_CLEAR)) begin
      nxt_irq_status = irq_status_ff & ~i_bus.wdata[3:0];
    end
    if (wr_hit(i_bus, roac_pkg::ADDR_IRQ_ENABLE)) begin
      nxt_irq_enable = i_bus.wdata[3:0];
    end
    nxt_irq_status = nxt_irq_status | irq_event;
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      irq_status_ff <= roac_pkg::IRQ_RESET;
      irq_enable_ff <= roac_pkg::IRQ_RESET;
      cap_ready_prev_ff <= 1'b1;
    end else begin
      irq_status_ff <= nxt_irq_status;
      irq_enable_ff <= nxt_irq_enable;
      cap_ready_prev_ff <= cap_ready;
    end
  end

  assign o_irq = |(irq_status_ff & irq_enable_ff);

  // ---------------- read port ----------------
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // unused and reserved bits stay zero; unmapped offsets read zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        roac_pkg::ADDR_OSC_CTRL: begin
          nxt_rdata[roac_pkg::OSC_GAIN_BIT] = osc_ff.gain;
          nxt_rdata[roac_pkg::OSC_MODE_BIT] = osc_ff.mode;
          nxt_rdata[roac_pkg::OSC_BIAS_BIT] = osc_ff.bias;
          nxt_rdata[roac_pkg::OSC_VALID_BIT] = osc_valid;
          nxt_rdata[roac_pkg::OSC_LFO_BIT] = osc_ff.lfo;
          nxt_rdata[2:0] = 3'h0;
        end
        roac_pkg::ADDR_CAP_CFG: begin
          nxt_rdata[roac_pkg::CAP_STEP_BIT] = cap_step_en_ff;
          nxt_rdata[roac_pkg::CAP_READY_BIT] = cap_ready;
          nxt_rdata[5:4] = 2'h0;
          nxt_rdata[roac_pkg::CAP_CODE_LSB +: 4] = cap_target_ff;
        end
        roac_pkg::ADDR_ALARM_CFG: begin
          nxt_rdata[roac_pkg::ALM_RSVD_BIT] = 1'b0;
          nxt_rdata[6:0] = alarm_ff;
        end
        roac_pkg::ADDR_IRQ_STATUS: begin
          nxt_rdata[3:0] = irq_status_ff;
        end
        roac_pkg::ADDR_IRQ_ENABLE: begin
          nxt_rdata[3:0] = irq_enable_ff;
        end
        default: begin
          nxt_rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

endmodule

`default_nettype wire

// [pkg/roac_pkg.sv]
// constants and carrier types for the rtc oscillator and alarm config block
package roac_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h05;
  localparam logic [7:0] ADDR_CAP_CFG = 8'h06;
  localparam logic [7:0] ADDR_ALARM_CFG = 8'h07;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h09;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h0a;

  // oscillator_control field positions
  localparam int OSC_GAIN_BIT = 7;
  localparam int OSC_MODE_BIT = 6;
  localparam int OSC_BIAS_BIT = 5;
  localparam int OSC_VALID_BIT = 4;
  localparam int OSC_LFO_BIT = 3;

  // load_capacitance_config field positions
  localparam int CAP_STEP_BIT = 7;
  localparam int CAP_READY_BIT = 6;
  localparam int CAP_CODE_LSB = 0;

  // alarm_configuration field positions
  localparam int ALM_RSVD_BIT = 7;
  localparam int ALM_FLAG_LSB = 4;
  localparam int ALM_AUTO_BIT = 3;
  localparam int ALM_EN_LSB = 0;

  // interrupt status, clear and enable layout
  localparam int IRQ_ALARM_LSB = 0;
  localparam int IRQ_CAP_READY_BIT = 3;
  localparam int IRQ_WIDTH = 4;

  // values after reset
  localparam logic [3:0] OSC_RESET = 4'h0;
  localparam logic [3:0] CAP_CODE_RESET = 4'h0;
  localparam logic [6:0] ALARM_RESET = 7'h00;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // load capacitance moves one code per step interval
  localparam int CLK_PERIOD_NS = 8;
  localparam int CAP_STEP_NS = 1000;
  localparam int CAP_STEP_CYCLES = CAP_STEP_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } roac_bus_t;

  typedef struct packed {
    logic gain;
    logic mode;
    logic bias;
    logic lfo;
  } roac_osc_t;

  typedef struct packed {
    logic [2:0] flag;
    logic auto_clear;
    logic [2:0] enable;
  } roac_alarm_t;

endpackage

// [dv/roac_core_asserts.sv]
// port-level assertions for roac_core, bound into every instance
`timescale 1ns/1ps
`default_nettype none
module roac_core_asserts (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire roac_pkg::roac_bus_t i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic o_gain_control_enable,
  input wire logic o_oscillator_mode_select,
  input wire logic o_bias_double_enable,
  input wire logic o_low_freq_osc_select,
  input wire logic o_crystal_select,
  input wire logic [3:0] o_cap_code,
  input wire logic o_timer_clear,
  input wire logic i_rtc_tick
);
  logic [3:0] osc;
  logic rd5, rd6, rd7, wr5;
  logic [7:0] wd_ff;
  logic [3:0] cap_ff;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // oscillator control outputs in register order, and decoded strobes
  assign osc = {o_gain_control_enable, o_oscillator_mode_select,
                o_bias_double_enable, o_low_freq_osc_select};
  assign rd5 = i_bus.rd && i_bus.addr == 8'h05;
  assign rd6 = i_bus.rd && i_bus.addr == 8'h06;
  assign rd7 = i_bus.rd && i_bus.addr == 8'h07;
  assign wr5 = i_bus.wr && i_bus.addr == 8'h05;
  // copies so a strobe can be compared with the result a cycle later
  always_ff @(posedge i_mclk) begin
    wd_ff <= i_bus.wdata;
    cap_ff <= o_cap_code;
  end
  a_crystal_source: assert property (
    o_crystal_select == (osc[2] & !osc[0]))
    else $error("crystal select does not follow mode and lfo");
  a_osc_write: assert property (
    wr5 |=> osc == {wd_ff[7:5], wd_ff[3]})
    else $error("oscillator outputs differ from written value");
  a_osc_hold: assert property (
    !wr5 |=> $stable(osc))
    else $error("oscillator outputs changed without a write");
  a_osc_low_zero: assert property (
    rd5 |=> o_rdata[2:0] == 3'h0)
    else $error("oscillator control low bits not zero");
  a_valid_needs_bias: assert property (
    rd5 && !o_bias_double_enable |=> !o_rdata[4])
    else $error("valid read high with bias double off");
  a_cap_rsvd_zero: assert property (
    rd6 |=> o_rdata[5:4] == 2'h0)
    else $error("capacitance config bits five and four not zero");
  a_ready_match: assert property (
    rd6 |=> o_rdata[6] == (o_rdata[3:0] == cap_ff))
    else $error("ready does not reflect applied equals target");
  a_alarm_top_zero: assert property (
    rd7 |=> !o_rdata[7])
    else $error("alarm config top bit not zero");
  a_timer_clear_tick: assert property (
    o_timer_clear |-> $past(i_rtc_tick) ##1 !o_timer_clear)
    else $error("timer clear not a single pulse after a tick");
endmodule
bind roac_core roac_core_asserts u_roac_chk (.i_mclk, .i_reset, .i_bus,
  .o_rdata, .o_gain_control_enable, .o_oscillator_mode_select,
  .o_bias_double_enable, .o_low_freq_osc_select, .o_crystal_select,
  .o_cap_code, .o_timer_clear, .i_rtc_tick);
`default_nettype wire

// [dv/testbench.sv]
// self-checking random bench for the rtc oscillator and alarm block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_mclk, i_reset, i_osc_amplitude_ok, i_rtc_tick;
  roac_pkg::roac_bus_t i_bus;
  logic [31:0] i_timer_value;
  logic [2:0][31:0] i_alarm_value;
  logic [7:0] o_rdata, v, d;
  logic o_gain_control_enable, o_oscillator_mode_select;
  logic o_bias_double_enable, o_low_freq_osc_select, o_crystal_select;
  logic o_timer_clear, o_irq;
  logic [3:0] o_cap_code, t, pc;
  int n_mismatch, samples_checked, n_clr, k;
  roac_core DUT (.i_mclk, .i_reset, .i_bus, .o_rdata, .i_osc_amplitude_ok,
    .i_rtc_tick, .i_timer_value, .i_alarm_value, .o_gain_control_enable,
    .o_oscillator_mode_select, .o_bias_double_enable, .o_low_freq_osc_select,
    .o_crystal_select, .o_cap_code, .o_timer_clear, .o_irq);
  // 125 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  // count timer clear pulses, sampled before the edge updates them
  always @(posedge i_mclk) begin
    if (o_timer_clear === 1'b1) n_clr++;
  end
  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // expected oscillator control read: valid needs amplitude and bias
  function automatic logic [7:0] exp_osc(input logic [7:0] w);
    exp_osc = {w[7:5], w[4] & w[5], w[3], 3'h0};
  endfunction
  // strobe driven on a rising edge; read data taken mid-cycle after it
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] x,
                     output logic [7:0] r);
    @(posedge i_mclk);
    i_bus <= '{a, x, w, !w};
    @(posedge i_mclk);
    i_bus <= '0;
    @(negedge i_mclk);
    r = o_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] r;
    acc(1'b0, a, 8'h00, r);
    chk(r, x);
  endtask
  task automatic tset(input logic [31:0] x);
    @(posedge i_mclk);
    i_timer_value <= x;
    @(negedge i_mclk);
  endtask
  // alarm 0 match then fall, then one oscillator tick
  task automatic tk();
    tset(32'h64);
    tset(32'h65);
    repeat (2) @(posedge i_mclk);
    i_rtc_tick <= 1'b1;
    @(posedge i_mclk);
    i_rtc_tick <= 1'b0;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  // watchdog: the sequence needs a few thousand cycles at most
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial begin
    void'($urandom(32'h000a));
    i_reset = 1'b1;
    i_bus = '0;
    i_osc_amplitude_ok = 1'b0;
    i_rtc_tick = 1'b0;
    i_timer_value = 32'h0;
    i_alarm_value = {32'h78, 32'h6e, 32'h64};
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    rc(8'h05, 8'h00);
    rc(8'h06, 8'h40);
    rc(8'h07, 8'h00);
    acc(1'b1, 8'h40, 8'hff, d);
    rc(8'h40, 8'h00);
    // random oscillator settings; amplitude rides on the read-only bit
    for (int i = 0; i < 24; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      i_osc_amplitude_ok <= v[4];
      acc(1'b1, 8'h05, v, d);
      repeat (3) @(posedge i_mclk);
      rc(8'h05, exp_osc(v));
      chk({4'h0, o_gain_control_enable, o_oscillator_mode_select,
           o_bias_double_enable, o_low_freq_osc_select},
          {4'h0, v[7:5], v[3]});
      chk({7'h0, o_crystal_select}, {7'h0, v[6] & !v[3]});
    end
    // stepping off: applied code takes the target at once
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom) & 8'h3f;
      acc(1'b1, 8'h06, v, d);
      rc(8'h06, {4'h4, v[3:0]});
      chk({4'h0, o_cap_code}, {4'h0, v[3:0]});
    end
    // stepping on: eight codes away and back, so both directions run
    for (int j = 0; j < 2; j++) begin
      pc = o_cap_code;
      t = pc ^ 4'h8;
      acc(1'b1, 8'h06, {4'h8, t}, d);
      rc(8'h06, {4'h8, t});
      for (k = 0; k < 1400 && o_cap_code !== t; k++) begin
        @(negedge i_mclk);
        if (o_cap_code !== pc) begin
          chk({4'h0, o_cap_code},
              {4'h0, pc + ((t > pc) ? 4'h1 : 4'hf)});
          pc = o_cap_code;
        end
      end
      rc(8'h06, {4'hc, t});
    end
    // alarms with auto clear on; near misses first
    acc(1'b1, 8'h09, 8'h0f, d);
    acc(1'b1, 8'h0a, 8'h0f, d);
    acc(1'b1, 8'h07, 8'h0f, d);
    tset(32'h63);
    tset(32'h65);
    rc(8'h07, 8'h0f);
    chk({7'h0, o_irq}, 8'h00);
    tk();
    chk(n_clr[7:0], 8'h01);
    rc(8'h07, 8'h1f);
    rc(8'h08, 8'h01);
    chk({7'h0, o_irq}, 8'h01);
    acc(1'b1, 8'h0a, 8'h00, d);
    chk({7'h0, o_irq}, 8'h00);
    // alarm 1 disabled, alarm 2 enabled, ones written to flags
    acc(1'b1, 8'h07, 8'h1d, d);
    tset(32'h6e);
    tset(32'h78);
    tset(32'h00);
    rc(8'h07, 8'h5d);
    acc(1'b1, 8'h07, 8'h7d, d);
    rc(8'h07, 8'h5d);
    acc(1'b1, 8'h07, 8'h05, d);
    rc(8'h07, 8'h05);
    tk();
    rc(8'h07, 8'h15);
    chk(n_clr[7:0], 8'h01);
    // status is read-only; clear register clears it and reads zero
    acc(1'b1, 8'h08, 8'h00, d);
    rc(8'h08, 8'h05);
    acc(1'b1, 8'h09, 8'h0f, d);
    rc(8'h08, 8'h00);
    rc(8'h09, 8'h00);
    acc(1'b1, 8'h0a, 8'h0f, d);
    chk({7'h0, o_irq}, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
